/* flic_ctrl.sv */
// Purpose: four level vectored interrupt controller for a small core
// Assumes: flags are level, cleared by software; core acks and returns
// Notes: keeps a stack of active levels so nesting unwinds correctly
`timescale 1ns/1ps
module flic_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // source flags
  input wire logic ext0_flag,
  input wire logic ext1_flag,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic serial_tx_done_flag,
  input wire logic serial_rx_done_flag,
  input wire logic brownout_flag,
  input wire logic i2c_attention_flag,
  input wire logic keypad_flag,
  input wire logic cmp_one_change_flag,
  input wire logic cmp_two_change_flag,
  input wire logic watchdog_overflow_flag,
  input wire logic adc_done_flag,
  input wire logic i2c_timer_flag,
  // configuration registers
  input wire logic [7:0] irq_enable_reg_a,
  input wire logic [7:0] irq_enable_reg_b,
  input wire logic [7:0] prio_low_reg_a,
  input wire logic [7:0] prio_high_reg_a,
  input wire logic [7:0] prio_low_reg_b,
  input wire logic [7:0] prio_high_reg_b,
  // core handshake
  output logic irq_req,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic [7:0] irq_vector,
  output logic [3:0] irq_source,
  // status
  output logic [3:0] active_levels,
  output logic wake_req
);
  // ----------------------------------------
  // request mapping and arbitration
  // ----------------------------------------
  logic [12:0] src_flag;
  logic [12:0] src_en;
  logic [12:0][1:0] src_lvl;
  logic [12:0] pend;
  logic global_irq_enable;
  logic win_valid;
  logic [3:0] win_idx;
  logic [1:0] win_lvl;

  assign global_irq_enable = irq_enable_reg_a[flic_pkg::EN_A_GLOBAL];

  flic_req_map u_map (
    .ext0_flag(ext0_flag),
    .ext1_flag(ext1_flag),
    .timer0_overflow_flag(timer0_overflow_flag),
    .timer1_overflow_flag(timer1_overflow_flag),
    .serial_tx_done_flag(serial_tx_done_flag),
    .serial_rx_done_flag(serial_rx_done_flag),
    .brownout_flag(brownout_flag),
    .i2c_attention_flag(i2c_attention_flag),
    .keypad_flag(keypad_flag),
    .cmp_one_change_flag(cmp_one_change_flag),
    .cmp_two_change_flag(cmp_two_change_flag),
    .watchdog_overflow_flag(watchdog_overflow_flag),
    .adc_done_flag(adc_done_flag),
    .i2c_timer_flag(i2c_timer_flag),
    .irq_enable_reg_a(irq_enable_reg_a),
    .irq_enable_reg_b(irq_enable_reg_b),
    .prio_low_reg_a(prio_low_reg_a),
    .prio_high_reg_a(prio_high_reg_a),
    .prio_low_reg_b(prio_low_reg_b),
    .prio_high_reg_b(prio_high_reg_b),
    .src_flag(src_flag),
    .src_en(src_en),
    .src_lvl(src_lvl)
  );

  // level pending, no latch: drops as soon as the flag clears
  assign pend = src_flag & src_en & {13{global_irq_enable}};

  flic_arbiter u_arb (
    .pend(pend),
    .lvl(src_lvl),
    .win_valid(win_valid),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  // vector from the slot table, slots 9 and 13 skipped
  function automatic logic [7:0] vec_of(input logic [3:0] idx);
    vec_of = flic_pkg::VEC_BASE +
             8'(flic_pkg::VEC_SLOT[idx] * flic_pkg::VEC_STEP);
  endfunction

  // ----------------------------------------
  // nesting state
  // ----------------------------------------
  // one bit per level in service; the highest set bit is the running level
  logic [3:0] act_q, act_d;
  logic [7:0] vec_q, vec_d;
  logic [3:0] src_q, src_d;
  logic run_any;
  logic [1:0] run_lvl;
  logic preempt_ok;

  always_comb begin
    run_any = |act_q;
    run_lvl = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (act_q[l]) begin
        run_lvl = 2'(l);
      end
    end
    // strictly higher only; top level can never be exceeded
    preempt_ok = win_valid &&
                 (!run_any || (win_lvl > run_lvl)) &&
                 !(run_any && run_lvl == flic_pkg::LVL_TOP);
  end

  always_comb begin
    act_d = act_q;
    vec_d = vec_q;
    src_d = src_q;
    // a return and an ack in one cycle both apply; the ack is judged on the levels held before the return
    if (irq_return && run_any) begin
      act_d[run_lvl] = 1'b0;
    end
    if (irq_ack && preempt_ok) begin
      act_d[win_lvl] = 1'b1;
    end
    if (preempt_ok) begin
      vec_d = vec_of(win_idx);
      src_d = win_idx;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      act_q <= 4'h0;
      vec_q <= flic_pkg::VEC_NONE;
      src_q <= 4'hf;
    end else begin
      act_q <= act_d;
      vec_q <= vec_d;
      src_q <= src_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // request is combinational so a withdrawn flag drops it at once
  assign irq_req = preempt_ok;
  assign irq_vector = vec_q;
  assign irq_source = src_q;
  assign active_levels = act_q;
  // wake ignores levels: any enabled wake source restarts the core
  assign wake_req = |(pend & flic_pkg::WAKE_MASK);
endmodule // flic_ctrl

/* flic_pkg.sv */
// Purpose: shared constants for the four level interrupt controller
// Assumes: sources are indexed in vector order, index 0 = lowest vector
// Notes: vector of source i is base + 8*slot(i); slots 9 and 13 are unused
package flic_pkg;
  localparam int unsigned NUM_SRC = 13;
  localparam int unsigned LVL_W = 2;
  localparam int unsigned VEC_W = 8;
  localparam int unsigned IDX_W = 4;
  // ----------------------------------------
  // source index (vector order)
  // ----------------------------------------
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_TMR0 = 4'h1;
  localparam logic [3:0] SRC_EXT1 = 4'h2;
  localparam logic [3:0] SRC_TMR1 = 4'h3;
  localparam logic [3:0] SRC_SER = 4'h4;
  localparam logic [3:0] SRC_BRWN = 4'h5;
  localparam logic [3:0] SRC_I2C = 4'h6;
  localparam logic [3:0] SRC_KEY = 4'h7;
  localparam logic [3:0] SRC_CMP2 = 4'h8;
  localparam logic [3:0] SRC_WDOG = 4'h9;
  localparam logic [3:0] SRC_ADC = 4'ha;
  localparam logic [3:0] SRC_CMP1 = 4'hb;
  localparam logic [3:0] SRC_TMRI = 4'hc;
  // ----------------------------------------
  // enable register bit positions
  // ----------------------------------------
  localparam int unsigned EN_A_EXT0 = 0;
  localparam int unsigned EN_A_TMR0 = 1;
  localparam int unsigned EN_A_EXT1 = 2;
  localparam int unsigned EN_A_TMR1 = 3;
  localparam int unsigned EN_A_SER = 4;
  localparam int unsigned EN_A_BRWN = 5;
  localparam int unsigned EN_A_WDOG = 6;
  localparam int unsigned EN_A_GLOBAL = 7;
  localparam int unsigned EN_B_I2C = 0;
  localparam int unsigned EN_B_KEY = 1;
  localparam int unsigned EN_B_CMP2 = 2;
  localparam int unsigned EN_B_ADC = 4;
  localparam int unsigned EN_B_CMP1 = 5;
  localparam int unsigned EN_B_TMRI = 7;
  // ----------------------------------------
  // vector table and rank (1 highest)
  // ----------------------------------------
  localparam logic [7:0] VEC_BASE = 8'h03;
  localparam logic [7:0] VEC_STEP = 8'h08;
  localparam logic [VEC_W-1:0] VEC_NONE = 8'h00;
  localparam logic [12:0][3:0] VEC_SLOT = {
    4'he, 4'hc, 4'hb, 4'ha, 4'h8, 4'h7, 4'h6,
    4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam logic [12:0][3:0] RANK = {
    4'hd, 4'h9, 4'h6, 4'h3, 4'hb, 4'h8, 4'h5,
    4'h2, 4'hc, 4'ha, 4'h7, 4'h4, 4'h1};
  // power down wake capable sources
  localparam logic [12:0] WAKE_MASK = 13'h0fa5;
  localparam logic [LVL_W-1:0] LVL_TOP = 2'h3;
endpackage

/* flic_req_map.sv */
// Purpose: maps flags, enables and priority bits to per source vectors
// Assumes: flags come from logic on the same clock
// Notes: purely combinational
`timescale 1ns/1ps
module flic_req_map (
  // flags
  input wire logic ext0_flag,
  input wire logic ext1_flag,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic serial_tx_done_flag,
  input wire logic serial_rx_done_flag,
  input wire logic brownout_flag,
  input wire logic i2c_attention_flag,
  input wire logic keypad_flag,
  input wire logic cmp_one_change_flag,
  input wire logic cmp_two_change_flag,
  input wire logic watchdog_overflow_flag,
  input wire logic adc_done_flag,
  input wire logic i2c_timer_flag,
  // registers
  input wire logic [7:0] irq_enable_reg_a,
  input wire logic [7:0] irq_enable_reg_b,
  input wire logic [7:0] prio_low_reg_a,
  input wire logic [7:0] prio_high_reg_a,
  input wire logic [7:0] prio_low_reg_b,
  input wire logic [7:0] prio_high_reg_b,
  // per source results
  output logic [12:0] src_flag,
  output logic [12:0] src_en,
  output logic [12:0][1:0] src_lvl
);
  // enable and priority bits share the same bit position per source
  logic [12:0][3:0] pos;
  logic [12:0] in_b;
  always_comb begin
    pos = '0;
    in_b = 13'h1fc0;
    pos[flic_pkg::SRC_EXT0] = 4'(flic_pkg::EN_A_EXT0);
    pos[flic_pkg::SRC_TMR0] = 4'(flic_pkg::EN_A_TMR0);
    pos[flic_pkg::SRC_EXT1] = 4'(flic_pkg::EN_A_EXT1);
    pos[flic_pkg::SRC_TMR1] = 4'(flic_pkg::EN_A_TMR1);
    pos[flic_pkg::SRC_SER] = 4'(flic_pkg::EN_A_SER);
    pos[flic_pkg::SRC_BRWN] = 4'(flic_pkg::EN_A_BRWN);
    pos[flic_pkg::SRC_I2C] = 4'(flic_pkg::EN_B_I2C);
    pos[flic_pkg::SRC_KEY] = 4'(flic_pkg::EN_B_KEY);
    pos[flic_pkg::SRC_CMP2] = 4'(flic_pkg::EN_B_CMP2);
    pos[flic_pkg::SRC_WDOG] = 4'(flic_pkg::EN_A_WDOG);
    pos[flic_pkg::SRC_ADC] = 4'(flic_pkg::EN_B_ADC);
    pos[flic_pkg::SRC_CMP1] = 4'(flic_pkg::EN_B_CMP1);
    pos[flic_pkg::SRC_TMRI] = 4'(flic_pkg::EN_B_TMRI);
    in_b[flic_pkg::SRC_WDOG] = 1'b0;
  end

  always_comb begin
    src_flag = '0;
    src_flag[flic_pkg::SRC_EXT0] = ext0_flag;
    src_flag[flic_pkg::SRC_TMR0] = timer0_overflow_flag;
    src_flag[flic_pkg::SRC_EXT1] = ext1_flag;
    src_flag[flic_pkg::SRC_TMR1] = timer1_overflow_flag;
    // tx and rx done share one source
    src_flag[flic_pkg::SRC_SER] = serial_tx_done_flag |
                                  serial_rx_done_flag;
    src_flag[flic_pkg::SRC_BRWN] = brownout_flag;
    src_flag[flic_pkg::SRC_I2C] = i2c_attention_flag;
    src_flag[flic_pkg::SRC_KEY] = keypad_flag;
    src_flag[flic_pkg::SRC_CMP2] = cmp_two_change_flag;
    src_flag[flic_pkg::SRC_WDOG] = watchdog_overflow_flag;
    src_flag[flic_pkg::SRC_ADC] = adc_done_flag;
    src_flag[flic_pkg::SRC_CMP1] = cmp_one_change_flag;
    src_flag[flic_pkg::SRC_TMRI] = i2c_timer_flag;
  end

  always_comb begin
    for (int i = 0; i < 13; i++) begin
      if (in_b[i]) begin
        src_en[i] = irq_enable_reg_b[pos[i][2:0]];
        src_lvl[i] = {prio_high_reg_b[pos[i][2:0]],
                      prio_low_reg_b[pos[i][2:0]]};
      end else begin
        src_en[i] = irq_enable_reg_a[pos[i][2:0]];
        src_lvl[i] = {prio_high_reg_a[pos[i][2:0]],
                      prio_low_reg_a[pos[i][2:0]]};
      end
    end
  end
endmodule // flic_req_map

/* flic_arbiter.sv */
// Purpose: picks the winning pending source by level, then by rank
// Assumes: pending vector already gated by enables
// Notes: combinational; level first, rank only breaks ties
`timescale 1ns/1ps
module flic_arbiter (
  // request side
  input wire logic [12:0] pend,
  input wire logic [12:0][1:0] lvl,
  // result
  output logic win_valid,
  output logic [3:0] win_idx,
  output logic [1:0] win_lvl
);
  // true when candidate a beats current best b
  function automatic logic beats(input logic [1:0] la, input logic [3:0] ra,
                                 input logic [1:0] lb, input logic [3:0] rb);
    beats = (la > lb) || ((la == lb) && (ra < rb));
  endfunction

  logic [3:0] best_rank;
  always_comb begin
    win_valid = 1'b0;
    win_idx = 4'h0;
    win_lvl = 2'h0;
    best_rank = 4'hf;
    for (int i = 0; i < 13; i++) begin
      if (pend[i] && (!win_valid ||
          beats(lvl[i], flic_pkg::RANK[i], win_lvl, best_rank))) begin
        win_valid = 1'b1;
        win_idx = 4'(i);
        win_lvl = lvl[i];
        best_rank = flic_pkg::RANK[i];
      end
    end
  end
endmodule // flic_arbiter

/* flic_ctrl_chk.sv */
// Purpose: concurrent checks on the interrupt controller ports
// Assumes: bound into every flic_ctrl instance
// Notes: the pending map is rebuilt here from the source table
`timescale 1ns/1ps
module flic_ctrl_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // source flags
  input wire logic ext0_flag,
  input wire logic ext1_flag,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic serial_tx_done_flag,
  input wire logic serial_rx_done_flag,
  input wire logic brownout_flag,
  input wire logic i2c_attention_flag,
  input wire logic keypad_flag,
  input wire logic cmp_one_change_flag,
  input wire logic cmp_two_change_flag,
  input wire logic watchdog_overflow_flag,
  input wire logic adc_done_flag,
  input wire logic i2c_timer_flag,
  // configuration
  input wire logic [7:0] irq_enable_reg_a,
  input wire logic [7:0] irq_enable_reg_b,
  input wire logic [7:0] prio_low_reg_a,
  input wire logic [7:0] prio_high_reg_a,
  // core side
  input wire logic irq_req,
  input wire logic irq_ack,
  input wire logic irq_return,
  input wire logic [7:0] irq_vector,
  input wire logic [3:0] irq_source,
  input wire logic [3:0] active_levels,
  input wire logic wake_req
);
  wire [7:0] a = irq_enable_reg_a;
  wire [7:0] b = irq_enable_reg_b;
  logic [12:0] pend;
  // vector order, index 0 is the lowest vector
  assign pend = {13{a[7]}} & {b[7] & i2c_timer_flag,
    b[5] & cmp_one_change_flag, b[4] & adc_done_flag,
    a[6] & watchdog_overflow_flag, b[2] & cmp_two_change_flag,
    b[1] & keypad_flag, b[0] & i2c_attention_flag, a[5] & brownout_flag,
    a[4] & (serial_tx_done_flag | serial_rx_done_flag),
    a[3] & timer1_overflow_flag, a[2] & ext1_flag,
    a[1] & timer0_overflow_flag, a[0] & ext0_flag};
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_GLOBAL_OFF: assert property (!a[7] |-> !irq_req && !wake_req)
    else $error("request while globally disabled");
  AST_IDLE_REQ: assert property (active_levels == 4'h0 |->
    irq_req == |pend)
    else $error("idle request differs from pending");
  AST_WAKE: assert property (wake_req == |(pend & 13'h0fa5))
    else $error("wake request wrong");
  AST_TOP_HOLD: assert property (active_levels[3] |-> !irq_req)
    else $error("request while top level in service");
  AST_NEST_UP: assert property (irq_req && irq_ack && !irq_return |=>
    (active_levels ^ $past(active_levels)) > $past(active_levels))
    else $error("taken level not above levels in service");
  AST_UNWIND: assert property (irq_return && !irq_ack &&
    |active_levels |=> $countones(active_levels) ==
    $countones($past(active_levels)) - 1)
    else $error("return did not retire one level");
  // slots 9 and 13 of the vector table are unused
  AST_VEC_FORM: assert property (irq_source < 4'hd |->
    irq_vector == 8'h03 + {irq_source + 4'(irq_source > 4'h8) +
    4'(irq_source > 4'hb), 3'h0})
    else $error("vector does not match source");
  // the release edge still loads reset values, so it is left out
  AST_TOP_EXT0: assert property (!reset && pend[0] &&
    prio_high_reg_a[0] && prio_low_reg_a[0] && !active_levels[3] |=>
    irq_source == 4'h0)
    else $error("top level first source lost");
  AST_SERIAL: assert property (!reset && pend == 13'h0010 &&
    !active_levels |=> irq_vector == 8'h23 && irq_source == 4'h4)
    else $error("serial vector wrong");
endmodule // flic_ctrl_chk
bind flic_ctrl flic_ctrl_chk flic_ctrl_chk_inst (.*);

/* flic_core_model.sv */
// Purpose: core side that takes and retires interrupts
// Assumes: the bench asks for each return through ret_cmd
// Notes: a late ack may land after irq_req fell; it must be ignored
`timescale 1ns/1ps
module flic_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // controller side
  input wire logic irq_req,
  output logic irq_ack = 1'b0,
  output logic irq_return = 1'b0,
  // bench control
  input wire logic [1:0] ack_delay,
  input wire logic ret_cmd
);
  logic [1:0] wait_q = 2'h0;
  always @(posedge clk) begin
    irq_ack <= 1'b0;
    irq_return <= ret_cmd & ~reset;
    if (reset || !irq_req || irq_ack) begin
      wait_q <= 2'h0;
    end else if (wait_q == ack_delay) begin
      irq_ack <= 1'b1;
      wait_q <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule // flic_core_model

/* flic_ctrl_tb.sv */
// Purpose: self-checking bench for flic_ctrl
// Assumes: the core model acks whatever it sees requested
// Notes: the table model is compared at every falling edge
`timescale 1ns/1ps
module flic_ctrl_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [13:0] fl = 14'h0;
  logic [7:0] irq_enable_reg_a = 8'hff;
  logic [7:0] irq_enable_reg_b = 8'hff;
  logic [7:0] prio_low_reg_a = 8'h00;
  logic [7:0] prio_high_reg_a = 8'h00;
  logic [7:0] prio_low_reg_b = 8'h00;
  logic [7:0] prio_high_reg_b = 8'h00;
  logic irq_req, irq_ack, irq_return, wake_req, ret_cmd = 1'b0;
  logic [7:0] irq_vector, mvec = 8'h00;
  logic [3:0] irq_source, active_levels, mact = 4'h0, msrc = 4'hf;
  logic [1:0] ack_delay = 2'h0;
  int num_errors = 0;
  int samples_checked = 0;
  // enable and priority bit of each source within {reg_b, reg_a}
  int pos[13] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 6, 12, 13, 15};
  int rk[13] = '{1, 4, 7, 10, 12, 2, 5, 8, 11, 3, 6, 9, 13};
  logic [12:0] wkm = 13'h0fa5;
  flic_ctrl flic_ctrl_inst (.*, .ext0_flag(fl[0]),
    .timer0_overflow_flag(fl[1]), .ext1_flag(fl[2]),
    .timer1_overflow_flag(fl[3]), .serial_tx_done_flag(fl[4]),
    .serial_rx_done_flag(fl[13]), .brownout_flag(fl[5]),
    .i2c_attention_flag(fl[6]), .keypad_flag(fl[7]),
    .cmp_two_change_flag(fl[8]), .watchdog_overflow_flag(fl[9]),
    .adc_done_flag(fl[10]), .cmp_one_change_flag(fl[11]),
    .i2c_timer_flag(fl[12]));
  flic_core_model flic_core_model_inst (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // wait for a take, then clear all flags or just the winner's, and return
  task automatic retire(input logic all);
    int k;
    logic [3:0] s;
    for (k = 0; k < 20 && active_levels === 4'h0; k++) @(negedge clk);
    if (k == 20) begin
      num_errors++;
      wrap_up();
    end
    // taken source, read while it stands and not at the launching edge
    s = irq_source;
    @(posedge clk);
    fl <= fl & ~(all ? 14'h3fff :
      (s == 4'h4 ? 14'h2010 : 14'h1 << s));
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  always @(negedge clk) begin : model
    logic [15:0] en, lo, hi;
    logic [12:0] sf;
    logic [1:0] lv, wl;
    logic wk, er;
    int w, c;
    en = {irq_enable_reg_b, irq_enable_reg_a};
    lo = {prio_low_reg_b, prio_low_reg_a};
    hi = {prio_high_reg_b, prio_high_reg_a};
    sf = fl[12:0] | {8'h00, fl[13], 4'h0};
    w = -1;
    wl = 2'h0;
    wk = 1'b0;
    c = -1;
    for (int i = 0; i < 13; i++) begin
      lv = {hi[pos[i]], lo[pos[i]]};
      if (sf[i] && en[pos[i]] && en[7]) begin
        wk |= wkm[i];
        if (w < 0 || lv > wl ||
            (lv == wl && rk[i] < rk[w])) begin
          w = i;
          wl = lv;
        end
      end
    end
    for (int j = 0; j < 4; j++) if (mact[j]) c = j;
    er = w >= 0 && int'(wl) > c;
    check(irq_req, er);
    check(wake_req, wk);
    check(irq_vector, mvec);
    check(irq_source, msrc);
    check(active_levels, mact);
    if (reset) begin
      mact = 4'h0;
      mvec = 8'h00;
      msrc = 4'hf;
    end else begin
      if (irq_return && c >= 0) mact[c] = 1'b0;
      if (irq_ack && er) mact[wl] = 1'b1;
      if (er) begin
        msrc = w[3:0];
        // vector slots 9 and 13 are unused
        mvec = 8'(3 + 8 * (w < 9 ? w : (w < 12 ? w + 1 : w + 2)));
      end
    end
  end
  initial forever #20 clk = ~clk;
  initial begin
    void'($urandom(18));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // each source alone, serial rx last
    for (int i = 0; i < 14; i++) begin
      @(posedge clk);
      fl <= 14'h1 << i;
      retire(1'b1);
    end
    // all sources at one level drain in rank order
    for (int l = 0; l < 4; l++) begin
      @(posedge clk);
      prio_low_reg_a <= {8{l[0]}};
      prio_low_reg_b <= {8{l[0]}};
      prio_high_reg_a <= {8{l[1]}};
      prio_high_reg_b <= {8{l[1]}};
      fl <= 14'h3fff;
      repeat (13) retire(1'b0);
    end
    // random traffic with nesting, late acks and a reset in mid-run
    for (int n = 0; n < 3000; n++) begin
      @(posedge clk);
      reset <= n >= 1500 && n < 1503;
      if ($urandom % 6 == 0) fl <= 14'($urandom);
      if ($urandom % 40 == 0) begin
        irq_enable_reg_a <= 8'($urandom) | ($urandom % 4 ? 8'h80 : 8'h00);
        irq_enable_reg_b <= 8'($urandom);
        prio_low_reg_a <= 8'($urandom);
        prio_high_reg_a <= 8'($urandom);
        prio_low_reg_b <= 8'($urandom);
        prio_high_reg_b <= 8'($urandom);
        ack_delay <= 2'($urandom);
      end
      ret_cmd <= $urandom % 5 == 0;
    end
    wrap_up();
  end
endmodule // flic_ctrl_tb
